/* design/essc_defs.svh */
// constants for the receive shaping and spread clocking configuration block
// assumes inclusion by bare name from the design module
`ifndef ESSC_DEFS_SVH
`define ESSC_DEFS_SVH

// register offsets
`define ESSC_OFS_CONFIG_1 8'h00
`define ESSC_OFS_SHAPING 8'h03

// config 1 fields
`define ESSC_LF_BIT 7
`define ESSC_SLEEP_BIT 1
`define ESSC_REGCTL_BIT 0

// shaping fields
`define ESSC_GAIN_HI 7
`define ESSC_GAIN_LO 5
`define ESSC_BOOST_ON_BIT 4
`define ESSC_SPREAD_HI 2
`define ESSC_SPREAD_LO 0

// reset values
`define ESSC_CONFIG_1_RST 8'h00
`define ESSC_SHAPING_RST 8'h00

// bus addresses chosen by the id strap
`define ESSC_ADDR_ID0 7'h71
`define ESSC_ADDR_ID1 7'h72
`define ESSC_ADDR_ID2 7'h73
`define ESSC_ADDR_ID3 7'h76

// modulation divisors of the pixel clock
`define ESSC_DIV_HF_LOW 12'h878
`define ESSC_DIV_HF_HIGH 12'h514
`define ESSC_DIV_LF_LOW 12'h271
`define ESSC_DIV_LF_HIGH 12'h181

// bits in a serial byte
`define ESSC_BYTE_BITS 4'h8

`endif

/* design/essc_pkg.sv */
// types for the receive shaping and spread clocking configuration block
// assumes essc_defs.svh is on the include path
package essc_pkg;

    typedef enum logic [8:0] {
        ESSC_IDLE = 9'h001,
        ESSC_ADDR = 9'h002,
        ESSC_AACK = 9'h004,
        ESSC_PTR = 9'h008,
        ESSC_PACK = 9'h010,
        ESSC_WR = 9'h020,
        ESSC_WACK = 9'h040,
        ESSC_RD = 9'h080,
        ESSC_RACK = 9'h100
    } essc_state_t;

endpackage

/* design/essc_config.sv */
// receive shaping and spread clocking configuration with its two-wire serial slave
// assumes scl, sda and all control pins are asynchronous; sda wire is resolved outside
`include "essc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module essc_config
    import essc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic power_down_inverted_input,
    input wire logic [1:0] bus_id_select,
    input wire logic [2:0] pin_boost_level,
    input wire logic pin_boost_on,
    input wire logic [2:0] pin_spread_select,
    input wire logic pin_low_freq,
    input wire logic rx_lock_raw,
    output logic [2:0] input_boost_level,
    output logic input_boost_on,
    output logic low_freq_range_select,
    output logic [2:0] spread_clocking_select,
    output logic spread_on,
    output logic [11:0] spread_divisor,
    output logic sleep_mode,
    output logic link_lock
);

    // ****************************************
    // functions
    // ****************************************
    function automatic logic [6:0] addr_of(input logic [1:0] id);
        case (id)
            2'h0: addr_of = `ESSC_ADDR_ID0;
            2'h1: addr_of = `ESSC_ADDR_ID1;
            2'h2: addr_of = `ESSC_ADDR_ID2;
            default: addr_of = `ESSC_ADDR_ID3;
        endcase
    endfunction

    // returns {enable, divisor}
    function automatic logic [12:0] spread_decode(input logic lf, input logic [2:0] code);
        if (code == 3'h0) begin
            spread_decode = 13'h0000;
        end else if (!lf) begin
            spread_decode = {1'b1, (code <= 3'h4) ? `ESSC_DIV_HF_LOW : `ESSC_DIV_HF_HIGH};
        end else begin
            // code 7 with the low range has no setting; it falls into the 385 group
            spread_decode = {1'b1, (code <= 3'h4) ? `ESSC_DIV_LF_LOW : `ESSC_DIV_LF_HIGH};
        end
    endfunction

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [13:0] sync1_reg;
    logic [13:0] sync2_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic [13:0] pins_raw;
    assign pins_raw = {scl_in, sda_in, power_down_inverted_input, bus_id_select, pin_boost_level,
                       pin_boost_on, pin_spread_select, pin_low_freq, rx_lock_raw};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_reg <= 14'h3000;
            sync2_reg <= 14'h3000;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            scl_prev_reg <= sync2_reg[13];
            sda_prev_reg <= sync2_reg[12];
        end
    end

    logic scl_s, sda_s, pdb_s, pin_on_s, pin_lf_s, lock_s;
    logic [1:0] id_s;
    logic [2:0] pin_lvl_s, pin_ss_s;
    assign scl_s = sync2_reg[13];
    assign sda_s = sync2_reg[12];
    assign pdb_s = sync2_reg[11];
    assign id_s = sync2_reg[10:9];
    assign pin_lvl_s = sync2_reg[8:6];
    assign pin_on_s = sync2_reg[5];
    assign pin_ss_s = sync2_reg[4:2];
    assign pin_lf_s = sync2_reg[1];
    assign lock_s = sync2_reg[0];

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_s && !scl_prev_reg;
    assign scl_fall = !scl_s && scl_prev_reg;
    assign bus_start = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    assign bus_stop = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

    // ****************************************
    // serial slave and registers
    // ****************************************
    essc_state_t state_reg, state_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] ptr_reg, ptr_next;
    logic rw_reg, rw_next;
    logic oe_reg, oe_next;
    logic [7:0] cfg1_reg, cfg1_next;
    logic [7:0] shaping_reg, shaping_next;
    logic [6:0] addr_reg, addr_next;
    logic addr_held_reg, addr_held_next;
    logic [7:0] rd_data;

    always_comb begin
        case (ptr_reg)
            `ESSC_OFS_CONFIG_1: rd_data = cfg1_reg;
            `ESSC_OFS_SHAPING: rd_data = shaping_reg;
            default: rd_data = 8'h00;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        oe_next = oe_reg;
        cfg1_next = cfg1_reg;
        shaping_next = shaping_reg;
        addr_next = addr_reg;
        addr_held_next = addr_held_reg;
        // strap tracked while power-down is held low, frozen at its release
        if (!addr_held_reg) begin
            addr_next = addr_of(id_s);
            addr_held_next = pdb_s;
        end
        if (bus_start) begin
            state_next = ESSC_ADDR;
            cnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (bus_stop) begin
            state_next = ESSC_IDLE;
            oe_next = 1'b0;
        end else if (scl_rise) begin
            case (state_reg)
                ESSC_ADDR, ESSC_PTR, ESSC_WR: begin
                    shift_next = {shift_reg[6:0], sda_s};
                    cnt_next = cnt_reg + 4'h1;
                end
                ESSC_RACK: begin
                    if (sda_s) begin
                        state_next = ESSC_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_reg)
                ESSC_ADDR: begin
                    if (cnt_reg == `ESSC_BYTE_BITS) begin
                        if (shift_reg[7:1] == addr_reg && addr_held_reg) begin
                            state_next = ESSC_AACK;
                            rw_next = shift_reg[0];
                            oe_next = 1'b1;
                        end else begin
                            state_next = ESSC_IDLE;
                        end
                    end
                end
                ESSC_AACK, ESSC_RACK: begin
                    cnt_next = 4'h0;
                    if (state_reg == ESSC_RACK) begin
                        ptr_next = ptr_reg + 8'h01;
                    end
                    if (rw_reg) begin
                        state_next = ESSC_RD;
                        shift_next = (state_reg == ESSC_RACK) ?
                            ((ptr_reg == 8'h02) ? shaping_reg : (ptr_reg == 8'hff) ? cfg1_reg : 8'h00) : rd_data;
                        oe_next = !((state_reg == ESSC_RACK) ?
                            ((ptr_reg == 8'h02) ? shaping_reg[7] : (ptr_reg == 8'hff) ? cfg1_reg[7] : 1'b0) :
                            rd_data[7]);
                    end else begin
                        state_next = ESSC_PTR;
                        oe_next = 1'b0;
                    end
                end
                ESSC_PTR, ESSC_WR: begin
                    if (cnt_reg == `ESSC_BYTE_BITS) begin
                        state_next = (state_reg == ESSC_PTR) ? ESSC_PACK : ESSC_WACK;
                        oe_next = 1'b1;
                        if (state_reg == ESSC_PTR) begin
                            ptr_next = shift_reg;
                        end else if (ptr_reg == `ESSC_OFS_CONFIG_1) begin
                            cfg1_next = shift_reg;
                        end else if (ptr_reg == `ESSC_OFS_SHAPING) begin
                            shaping_next = shift_reg;
                        end
                    end
                end
                ESSC_PACK, ESSC_WACK: begin
                    if (state_reg == ESSC_WACK) begin
                        ptr_next = ptr_reg + 8'h01;
                    end
                    state_next = ESSC_WR;
                    cnt_next = 4'h0;
                    oe_next = 1'b0;
                end
                ESSC_RD: begin
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == 4'h7) begin
                        state_next = ESSC_RACK;
                        oe_next = 1'b0;
                    end else begin
                        shift_next = {shift_reg[6:0], 1'b0};
                        oe_next = !shift_reg[6];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ESSC_IDLE;
            shift_reg <= 8'h00;
            cnt_reg <= 4'h0;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            oe_reg <= 1'b0;
            cfg1_reg <= `ESSC_CONFIG_1_RST;
            shaping_reg <= `ESSC_SHAPING_RST;
            addr_reg <= `ESSC_ADDR_ID3;
            addr_held_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            oe_reg <= oe_next;
            cfg1_reg <= cfg1_next;
            shaping_reg <= shaping_next;
            addr_reg <= addr_next;
            addr_held_reg <= addr_held_next;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = oe_reg;

    // ****************************************
    // effective configuration
    // ****************************************
    logic reg_mode, eff_lf, eff_on;
    logic [2:0] eff_lvl, eff_ss;
    logic [12:0] ss_dec;
    assign reg_mode = cfg1_reg[`ESSC_REGCTL_BIT];
    assign eff_lf = reg_mode ? cfg1_reg[`ESSC_LF_BIT] : pin_lf_s;
    assign eff_on = reg_mode ? shaping_reg[`ESSC_BOOST_ON_BIT] : pin_on_s;
    assign eff_lvl = reg_mode ? shaping_reg[`ESSC_GAIN_HI:`ESSC_GAIN_LO] : pin_lvl_s;
    assign eff_ss = reg_mode ? shaping_reg[`ESSC_SPREAD_HI:`ESSC_SPREAD_LO] : pin_ss_s;
    assign ss_dec = spread_decode(eff_lf, eff_ss);

    logic [22:0] out_reg, out_next;
    always_comb begin
        out_next = {eff_on ? eff_lvl : 3'h0, eff_on, eff_lf, eff_ss, ss_dec,
                    reg_mode & cfg1_reg[`ESSC_SLEEP_BIT], lock_s};
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_reg <= 23'h000000;
        end else begin
            out_reg <= out_next;
        end
    end

    assign {input_boost_level, input_boost_on, low_freq_range_select, spread_clocking_select,
            spread_on, spread_divisor, sleep_mode, link_lock} = out_reg;

    // ****************************************
    // assertions
    // ****************************************
    boost_level_a: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_mode && shaping_reg[4]) |=> input_boost_level == $past(shaping_reg[7:5]))
        else $error("boost level does not follow register");
    boost_off_a: assert property (@(posedge sys_clk) disable iff (rst)
        !eff_on |=> (!input_boost_on && input_boost_level == 3'h0))
        else $error("boost level applied while disabled");
    spread_high_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!eff_lf && eff_ss >= 3'h5) |=> (spread_on && spread_divisor == 12'h514))
        else $error("high range divisor wrong");
    spread_off_a: assert property (@(posedge sys_clk) disable iff (rst)
        (eff_ss == 3'h0) |=> !spread_on)
        else $error("spreading not off for code zero");
    spread_low_a: assert property (@(posedge sys_clk) disable iff (rst)
        (eff_lf && eff_ss != 3'h0 && eff_ss <= 3'h4) |=> spread_divisor == 12'h271)
        else $error("low range divisor wrong");
    range_select_a: assert property (@(posedge sys_clk) disable iff (rst)
        reg_mode |=> low_freq_range_select == $past(cfg1_reg[7]))
        else $error("range select does not follow register");
    pin_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
        !reg_mode |=> spread_clocking_select == $past(sync2_reg[4:2]))
        else $error("pin mode not taken from pins");
    lock_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
        ($past(rst, 3) == 1'b0 && $past(rst, 1) == 1'b0) |-> link_lock == $past(rx_lock_raw, 3))
        else $error("lock status late or wrong");

    reg_write_c: cover property (@(posedge sys_clk) disable iff (rst) state_reg == ESSC_WACK);
    reg_read_c: cover property (@(posedge sys_clk) disable iff (rst) state_reg == ESSC_RACK);
    lf_spread_c: cover property (@(posedge sys_clk) disable iff (rst) low_freq_range_select && spread_on);

endmodule

`default_nettype wire

/* testbench/essc_host_model.sv */
// two-wire serial bus host that configures the shaping block
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/100ps
`default_nettype none

module essc_host_model (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    // ****************************************
    // bus phases
    // ****************************************
    localparam int HALF = 8;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // also serves as repeated start
    task automatic start_cond;
        sda_pull <= 1'b0;
        wait_clk(HALF);
        scl <= 1'b1;
        wait_clk(HALF);
        sda_pull <= 1'b1;
        wait_clk(HALF);
        scl <= 1'b0;
        wait_clk(2);
    endtask

    task automatic stop_cond;
        sda_pull <= 1'b1;
        wait_clk(HALF);
        scl <= 1'b1;
        wait_clk(HALF);
        sda_pull <= 1'b0;
        wait_clk(HALF);
    endtask

    // data moves only while the clock is low, sampled at the end of high
    task automatic xfer_bit(input logic b, output logic r);
        sda_pull <= ~b;
        wait_clk(HALF);
        scl <= 1'b1;
        wait_clk(HALF);
        r = sda_line;
        scl <= 1'b0;
        wait_clk(2);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask

    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, d[i]);
        end
        xfer_bit(~ack, r);
    endtask

    // ****************************************
    // register transfers
    // ****************************************
    task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        logic a0;
        logic a1;
        logic a2;
        start_cond();
        send_byte({dev, 1'b0}, a0);
        a1 = 1'b0;
        a2 = 1'b0;
        if (a0) begin
            send_byte(ptr, a1);
            send_byte(d, a2);
        end
        stop_cond();
        ok = a0 & a1 & a2;
    endtask

    task automatic rd_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d, output logic ok);
        logic a0;
        logic a1;
        logic a2;
        start_cond();
        send_byte({dev, 1'b0}, a0);
        send_byte(ptr, a1);
        start_cond();
        send_byte({dev, 1'b1}, a2);
        recv_byte(1'b0, d);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask
endmodule

`default_nettype wire

/* testbench/tb.sv */
// self-checking bench of the shaping configuration block
// assumes the host model drives the bus; pins and straps are driven here
`timescale 1ns/100ps
`default_nettype none

module tb;
    import essc_pkg::*;
    logic sys_clk, rst, pdi, p_on, p_lf, lock_raw, scl, sda_pull, sda_out, sda_oe;
    logic on, lf, ss_on, slp, lk;
    logic [1:0] bus_id;
    logic [2:0] p_lvl, p_ss, lvl, ss;
    logic [11:0] div;
    logic [31:0] seed;
    int mismatches, tests_run, cycles;
    wire logic sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
    wire logic [21:0] outs = {lvl, on, lf, ss, ss_on, div, slp};

    essc_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

    essc_config DUT (.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .power_down_inverted_input(pdi), .bus_id_select(bus_id), .pin_boost_level(p_lvl),
        .pin_boost_on(p_on), .pin_spread_select(p_ss), .pin_low_freq(p_lf), .rx_lock_raw(lock_raw),
        .input_boost_level(lvl), .input_boost_on(on), .low_freq_range_select(lf),
        .spread_clocking_select(ss), .spread_on(ss_on), .spread_divisor(div), .sleep_mode(slp), .link_lock(lk));

    // ****************************************
    // helpers
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [21:0] exp_cfg(input logic l, input logic [2:0] g, input logic e, input logic [2:0] c,
        input logic s);
        logic [11:0] d;
        d = (c == 3'h0) ? 12'h000 : l ? ((c < 3'h5) ? 12'h271 : 12'h181) : ((c < 3'h5) ? 12'h878 : 12'h514);
        return {e ? g : 3'h0, e, l, c, c != 3'h0, d, s};
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            end_sim();
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic ok;
        logic old;
        logic [7:0] rd, sh, c1;
        logic [31:0] r;
        seed = 32'h1bcd;
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        {rst, pdi, p_on, p_lf, lock_raw, p_lvl, p_ss} = {1'b1, 10'h000};
        bus_id = 2'h2;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk({2'h0, outs}, 24'h0);
        host.wr_reg(7'h73, 8'h03, 8'hff, ok);
        chk({23'h0, ok}, 24'h0);
        pdi <= 1'b1;
        repeat (5) @(posedge sys_clk);
        bus_id <= 2'h0;
        repeat (5) @(posedge sys_clk);
        host.wr_reg(7'h71, 8'h00, 8'h01, ok);
        chk({23'h0, ok}, 24'h0);
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            {p_lvl, p_on, p_lf} <= r[4:0];
            p_ss <= (r[0] && r[7:5] == 3'h7) ? 3'h6 : r[7:5];
            repeat (6) @(posedge sys_clk);
            chk({2'h0, outs}, {2'h0, exp_cfg(p_lf, p_lvl, p_on, p_ss, 1'b0)});
        end
        for (int i = 0; i < 16; i++) begin
            if (i != 15) begin
                r = rnd();
                c1 = {i[3], r[12:10], 2'h0, r[8], 1'b1};
                sh = {r[2:0], r[3], r[4], i[2:0]};
                {p_lvl, p_on, p_lf, p_ss} <= r[31:24];
                host.wr_reg(7'h73, 8'h00, c1, ok);
                host.wr_reg(7'h73, 8'h03, sh, ok);
                repeat (6) @(posedge sys_clk);
                chk({2'h0, outs}, {2'h0, exp_cfg(i[3], sh[7:5], sh[4], sh[2:0], c1[1])});
                host.rd_reg(7'h73, 8'h03, rd, ok);
                chk({15'h0, ok, rd}, {15'h0, 1'b1, sh});
            end
        end
        host.wr_reg(7'h73, 8'h00, 8'h80, ok);
        repeat (6) @(posedge sys_clk);
        chk({2'h0, outs}, {2'h0, exp_cfg(p_lf, p_lvl, p_on, p_ss, 1'b0)});
        host.rd_reg(7'h73, 8'h05, rd, ok);
        chk({15'h0, ok, rd}, 24'h000100);
        for (int i = 0; i < 4; i++) begin
            old = lk;
            lock_raw <= ~old;
            @(posedge sys_clk);
            chk({23'h0, lk}, {23'h0, old});
            repeat (5) @(posedge sys_clk);
            chk({23'h0, lk}, {23'h0, ~old});
        end
        end_sim();
    end
endmodule

`default_nettype wire
